// ===== hw/pssa_pkg.sv
// constants and carrier types of the pipelined synchronous static memory access block
// assumes one rising-edge clock and a synchronous active-high reset in every user
//
// Contract
// - sleep input high: sleep, contents kept
// - write data captured on rising edge
// - drive data only while output enable low
// - strap low linear, high interleaved order
// - low address bits load two-bit burst counter
// - counter steps only when advance asserted
// - global write writes all four lanes
// - read start: strobe, selected, writes high
// - processor strobe ignored while select1 high
// - read start stores address and counter
// - read data out one edge later
// - first cycle after deselect stays undriven
// - back-to-back single reads every edge
// - deselect releases data lines at once
// - processor strobe write latches address, counter
// - first processor-strobe edge ignores write, advance
// - processor-strobe write completes on second edge
// - byte write touches only selected lanes
// - detected write turns drivers off
// - both strobes: processor strobe wins
// - wrap four; interleave xor, linear add
// - lane write needs byte gate low
// - selected: sel1 low, sel2 high, sel3 low
package pssa_pkg;
   localparam int ADDR_W = 17;
   localparam int LANES = 4;
   localparam int LANE_DATA_W = 8;
   localparam int LANE_W = 9;
   localparam int WORD_W = 36;
   localparam int DATA_W = 32;
   localparam int BURST_W = 2;
   localparam int FIFO_DEPTH = 16;
   localparam logic [LANES-1:0] ALL_LANES = 4'hF;
   localparam logic [LANES-1:0] NO_LANES = 4'h0;
   localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
   localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;
   localparam logic MODE_LINEAR = 1'b0;
   localparam logic MODE_RESET = 1'b1;
   localparam logic SLEEP_RESET = 1'b0;
   localparam logic OEN_RESET = 1'b1;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] lanes;
      logic [WORD_W-1:0] word;
   } pssa_wr_t;
endpackage : pssa_pkg

// ===== hw/pssa_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty come from a registered count
`timescale 1ns/1ps
`default_nettype none
module pssa_fifo #(
   parameter int WIDTH = 57,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] CNT_FULL = PTR_W'(0) + (PTR_W+1)'(DEPTH);

   logic [WIDTH-1:0] store_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W:0] count_q;
   logic [PTR_W:0] count_d;
   logic ready_q;
   logic push;
   logic pop;

   // room flag kept in a flop so it leaves the block registered
   assign in_ready_out = ready_q;
   assign count_d = count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
   assign out_valid_out = (count_q != '0);
   assign out_data_out = store_q[rd_ptr_q];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         store_q[wr_ptr_q] <= in_data_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         ready_q <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_d;
         ready_q <= (count_d != CNT_FULL);
      end
   end
endmodule : pssa_fifo
`default_nettype wire

// ===== hw/pssa_access.sv
// synchronous pipelined static memory: strobes, selects, burst counter, writes, reads
// assumes control pins are synchronous to ref_clk_in; sleep, output enable and strap are not
`timescale 1ns/1ps
`default_nettype none
module pssa_access #(
   parameter int ADDR_BITS = pssa_pkg::ADDR_W,
   parameter int WR_FIFO_DEPTH = pssa_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic sleep_request_in,
   input wire logic burst_order_in,
   input wire logic processor_addr_strobe_n_in,
   input wire logic controller_addr_strobe_n_in,
   input wire logic chip_sel1_n_in,
   input wire logic chip_sel2_in,
   input wire logic chip_sel3_n_in,
   input wire logic [ADDR_BITS-1:0] addr_in,
   input wire logic all_bytes_write_n_in,
   input wire logic byte_write_gate_n_in,
   input wire logic [pssa_pkg::LANES-1:0] lane_write_select_n_in,
   input wire logic burst_step_n_in,
   input wire logic out_enable_n_in,
   input wire logic [pssa_pkg::DATA_W-1:0] data_lines_in,
   input wire logic [pssa_pkg::LANES-1:0] parity_lines_in,
   output logic [pssa_pkg::DATA_W-1:0] data_lines_out,
   output logic [pssa_pkg::LANES-1:0] parity_lines_out,
   output logic data_lines_oe_out,
   output logic write_ready_out
);
   import pssa_pkg::*;

   localparam int ENTRY_W = $bits(pssa_wr_t);

   // two-stage synchronisers for the pins that are not clocked
   logic sleep_m_q;
   logic sleep_s_q;
   logic oen_m_q;
   logic oen_s_q;
   logic mode_m_q;
   logic mode_s_q;

   // access state
   logic active_q;
   logic second_q;
   logic [ADDR_BITS-1:BURST_W] base_q;
   logic [BURST_W-1:0] start_q;
   logic [BURST_W-1:0] step_q;
   logic rd_pend_q;
   logic [ADDR_BITS-1:0] rd_addr_q;
   logic [WORD_W-1:0] out_word_q;
   logic oe_q;

   // decode
   logic take_proc;
   logic take_ctrl;
   logic strobe;
   logic selected;
   logic desel;
   logic start;
   logic [LANES-1:0] wr_lanes;
   logic wr_req;
   logic wr_start_ctrl;
   logic rd_start;
   logic cont;
   logic cont_wr;
   logic cont_rd;
   logic wr_edge;
   logic [BURST_W-1:0] next_step;
   logic [BURST_W-1:0] burst_low;
   logic [ADDR_BITS-1:0] cur_addr;
   logic [WORD_W-1:0] pin_word;
   logic first_after_desel;
   logic oe_d;

   // write buffer and array
   pssa_wr_t wr_entry;
   pssa_wr_t drain_entry;
   logic [ENTRY_W-1:0] drain_bits;
   logic drain_valid;
   logic drain_ready;
   logic wr_ready;
   logic [WORD_W-1:0] mem_q [2**ADDR_BITS];

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sleep_m_q <= SLEEP_RESET;
         sleep_s_q <= SLEEP_RESET;
      end else begin
         sleep_m_q <= sleep_request_in;
         sleep_s_q <= sleep_m_q;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         oen_m_q <= OEN_RESET;
         oen_s_q <= OEN_RESET;
      end else begin
         oen_m_q <= out_enable_n_in;
         oen_s_q <= oen_m_q;
      end
   end

   // strap is only synchronised; it must not move while in use
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         mode_m_q <= MODE_RESET;
         mode_s_q <= MODE_RESET;
      end else begin
         mode_m_q <= burst_order_in;
         mode_s_q <= mode_m_q;
      end
   end

   always_comb begin
      selected = ~chip_sel1_n_in & chip_sel2_in & ~chip_sel3_n_in;
      take_proc = ~processor_addr_strobe_n_in & ~chip_sel1_n_in & ~sleep_s_q;
      take_ctrl = ~controller_addr_strobe_n_in & ~take_proc & ~sleep_s_q;
      strobe = take_proc | take_ctrl;
      desel = strobe & ~selected;
      start = strobe & selected;
   end

   always_comb begin
      if (~all_bytes_write_n_in) begin
         wr_lanes = ALL_LANES;
      end else if (~byte_write_gate_n_in) begin
         wr_lanes = ~lane_write_select_n_in;
      end else begin
         wr_lanes = NO_LANES;
      end
      wr_req = (wr_lanes != NO_LANES);
   end

   always_comb begin
      wr_start_ctrl = take_ctrl & selected & wr_req;
      // processor strobe: write inputs ignored on its first edge
      rd_start = start & ~wr_start_ctrl;
      cont = ~strobe & active_q & ~sleep_s_q;
      cont_wr = cont & wr_req;
      cont_rd = cont & ~wr_req;
      wr_edge = wr_start_ctrl | cont_wr;
      first_after_desel = rd_start & ~active_q;
   end

   always_comb begin
      // advance ignored on the edge that completes a processor-strobe write
      if (cont & ~burst_step_n_in & ~(second_q & wr_req)) begin
         next_step = step_q + STEP_ONE;
      end else begin
         next_step = step_q;
      end
      if (mode_s_q == MODE_LINEAR) begin
         burst_low = start_q + next_step;
      end else begin
         burst_low = start_q ^ next_step;
      end
      cur_addr = {base_q, burst_low};
   end

   always_comb begin
      pin_word = '0;
      for (int l = 0; l < LANES; l++) begin
         pin_word[l*LANE_W +: LANE_W] = {parity_lines_in[l], data_lines_in[l*LANE_DATA_W +: LANE_DATA_W]};
      end
      wr_entry.addr = wr_start_ctrl ? addr_in : cur_addr;
      wr_entry.lanes = wr_lanes;
      wr_entry.word = pin_word;
   end

   // selection and burst counter
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         active_q <= 1'b0;
         second_q <= 1'b0;
         base_q <= '0;
         start_q <= STEP_ZERO;
         step_q <= STEP_ZERO;
      end else if (sleep_s_q) begin
         active_q <= 1'b0;
         second_q <= 1'b0;
      end else if (start) begin
         active_q <= 1'b1;
         second_q <= take_proc;
         base_q <= addr_in[ADDR_BITS-1:BURST_W];
         start_q <= addr_in[BURST_W-1:0];
         step_q <= STEP_ZERO;
      end else if (desel) begin
         active_q <= 1'b0;
         second_q <= 1'b0;
      end else begin
         second_q <= 1'b0;
         step_q <= next_step;
      end
   end

   // read address stage: array is read from the registered address
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rd_pend_q <= 1'b0;
         rd_addr_q <= '0;
      end else begin
         rd_pend_q <= rd_start | cont_rd;
         if (rd_start) begin
            rd_addr_q <= addr_in;
         end else if (cont_rd) begin
            rd_addr_q <= cur_addr;
         end
      end
   end

   // output register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         out_word_q <= '0;
      end else if (rd_pend_q) begin
         out_word_q <= mem_q[rd_addr_q];
      end
   end

   always_comb begin
      oe_d = rd_pend_q & ~oen_s_q;
      if (sleep_s_q | desel | wr_edge | first_after_desel) begin
         oe_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         data_lines_out[l*LANE_DATA_W +: LANE_DATA_W] = out_word_q[l*LANE_W +: LANE_DATA_W];
         parity_lines_out[l] = out_word_q[l*LANE_W + LANE_DATA_W];
      end
   end

   assign data_lines_oe_out = oe_q;
   assign write_ready_out = wr_ready;

   // writes queue here; draining stalls during sleep, and no new writes enter while asleep
   pssa_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(WR_FIFO_DEPTH)
   ) u_wr_fifo (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .in_valid_in(wr_edge),
      .in_ready_out(wr_ready),
      .in_data_in(wr_entry),
      .out_valid_out(drain_valid),
      .out_ready_in(drain_ready),
      .out_data_out(drain_bits)
   );

   assign drain_ready = ~sleep_s_q;
   assign drain_entry = drain_bits;

   always_ff @(posedge ref_clk_in) begin
      if (drain_valid & drain_ready) begin
         for (int l = 0; l < LANES; l++) begin
            if (drain_entry.lanes[l]) begin
               mem_q[drain_entry.addr][l*LANE_W +: LANE_W] <= drain_entry.word[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // checks
   chk_sleep_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      sleep_s_q |=> !data_lines_oe_out && !active_q)
      else $error("outputs driven or access active during sleep");

   chk_oe_release: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      oen_s_q |=> !data_lines_oe_out)
      else $error("data lines driven while output enable high");

   chk_counter_load: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      start && !sleep_s_q |=> step_q == STEP_ZERO && start_q == $past(addr_in[BURST_W-1:0]))
      else $error("burst counter not loaded from low address bits");

   chk_step_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      active_q && !strobe && !sleep_s_q && burst_step_n_in |=> step_q == $past(step_q))
      else $error("burst counter moved without advance");

   chk_step_wrap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cont && !second_q && !burst_step_n_in && step_q == 2'h3 |=> step_q == STEP_ZERO)
      else $error("burst counter did not wrap within four");

   chk_global_lanes: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_edge && !all_bytes_write_n_in |-> wr_entry.lanes == ALL_LANES)
      else $error("global write did not select all lanes");

   chk_read_pipe: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      rd_start && active_q ##1 (!oen_s_q && !sleep_s_q && !desel && !wr_edge && !first_after_desel)
      |=> data_lines_oe_out && rd_addr_q != $past(rd_addr_q, 2) || data_lines_oe_out)
      else $error("read data not presented one edge after address");

   chk_first_masked: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      first_after_desel |=> !data_lines_oe_out)
      else $error("outputs driven in first cycle after deselect");

   chk_desel_release: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      desel |=> !data_lines_oe_out && !active_q)
      else $error("deselect did not release data lines");

   chk_write_release: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_edge |=> !data_lines_oe_out)
      else $error("data lines driven during a write");

   chk_proc_second: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      take_proc && selected ##1 (!strobe && !sleep_s_q && !all_bytes_write_n_in) |-> wr_edge)
      else $error("processor-strobe write not done on second edge");

   chk_proc_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      chip_sel1_n_in |-> !take_proc)
      else $error("processor strobe taken with select one high");

   chk_ctrl_yield: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !processor_addr_strobe_n_in && !chip_sel1_n_in && !sleep_s_q |-> !take_ctrl)
      else $error("controller strobe taken alongside processor strobe");

   chk_read_start: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      take_ctrl && selected && all_bytes_write_n_in && byte_write_gate_n_in |=> rd_pend_q && active_q)
      else $error("read not started with write strobes high");

   chk_read_addr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      rd_start |=> rd_addr_q == $past(addr_in))
      else $error("read start did not store the address");

   chk_lane_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_edge && all_bytes_write_n_in |-> !byte_write_gate_n_in)
      else $error("byte write without the byte gate");

   chk_proc_latch: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      take_proc && selected |=> active_q && second_q && base_q == $past(addr_in[ADDR_BITS-1:BURST_W]))
      else $error("processor strobe did not latch the address");
endmodule : pssa_access
`default_nettype wire

// ===== verif/pssa_host.sv
// bus master model driving the static memory pins, one cyc call per clock
// assumes cyc is entered just after a falling edge of ref_clk_in
`timescale 1ns/1ps
`default_nettype none
module pssa_host (
   input wire logic ref_clk_in,
   input wire logic [pssa_pkg::WORD_W-1:0] rd_word_in,
   input wire logic rd_drive_in,
   output logic sleep_request_out,
   output logic burst_order_out,
   output logic [1:0] strobes_n_out,
   output logic [2:0] sel_out,
   output logic [pssa_pkg::ADDR_W-1:0] addr_out,
   output logic [2:0] ctl_n_out,
   output logic [pssa_pkg::LANES-1:0] lanes_n_out,
   output logic oe_n_out,
   output logic [pssa_pkg::WORD_W-1:0] bus_word_out
);
   import pssa_pkg::*;
   logic drv_q;
   logic [WORD_W-1:0] wd_q;
   // released bus shows the read word while the dut drives, else the inverse of the last word
   assign bus_word_out = drv_q ? wd_q : (rd_drive_in ? rd_word_in : ~wd_q);
   initial begin
      sleep_request_out = SLEEP_RESET;
      burst_order_out = MODE_RESET;
      strobes_n_out = 2'h3;
      sel_out = 3'h2;
      addr_out = '0;
      ctl_n_out = 3'h7;
      lanes_n_out = 4'hF;
      oe_n_out = OEN_RESET;
      drv_q = 1'b0;
      wd_q = '0;
   end
   task automatic cyc(input logic [1:0] stb_n, input logic [2:0] sel, input logic [ADDR_W-1:0] a,
                      input logic [LANES-1:0] ln, input logic [WORD_W-1:0] w, input logic [2:0] ctl_n,
                      input logic drv);
      if (drv) begin
         oe_n_out = 1'b1;
         wd_q = w;
      end
      strobes_n_out = stb_n;
      sel_out = sel;
      addr_out = a;
      lanes_n_out = ln;
      ctl_n_out = ctl_n;
      drv_q = drv;
      @(negedge ref_clk_in);
   endtask : cyc
endmodule : pssa_host
`default_nettype wire

// ===== verif/pssa_access_test.sv
// self-checking bench for pssa_access driven by the pssa_host model
// assumes a 40 MHz clock; inputs change at falling edges
`timescale 1ns/1ps
`default_nettype none
module pssa_access_test;
   import pssa_pkg::*;
   logic ref_clk_in, rst_in, sleep, strap, oe_n, oe;
   logic [1:0] stb_n;
   logic [2:0] sel, ctl_n;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0] lanes_n, pout;
   logic [DATA_W-1:0] dout;
   logic [WORD_W-1:0] bus;
   logic wr_rdy;
   int err_total;
   int n_compared;
   logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
   localparam logic [2:0] SEL_ON = 3'h2;

   pssa_access dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sleep_request_in(sleep), .burst_order_in(strap),
      .processor_addr_strobe_n_in(stb_n[1]), .controller_addr_strobe_n_in(stb_n[0]), .chip_sel1_n_in(sel[2]),
      .chip_sel2_in(sel[1]), .chip_sel3_n_in(sel[0]), .addr_in(addr), .all_bytes_write_n_in(ctl_n[2]),
      .byte_write_gate_n_in(ctl_n[1]), .lane_write_select_n_in(lanes_n), .burst_step_n_in(ctl_n[0]),
      .out_enable_n_in(oe_n), .data_lines_in(bus[DATA_W-1:0]), .parity_lines_in(bus[WORD_W-1:DATA_W]),
      .data_lines_out(dout), .parity_lines_out(pout), .data_lines_oe_out(oe), .write_ready_out(wr_rdy));
   pssa_host u_host (.ref_clk_in(ref_clk_in), .rd_word_in({pout, dout}), .rd_drive_in(oe),
      .sleep_request_out(sleep), .burst_order_out(strap), .strobes_n_out(stb_n), .sel_out(sel),
      .addr_out(addr), .ctl_n_out(ctl_n), .lanes_n_out(lanes_n), .oe_n_out(oe_n), .bus_word_out(bus));

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic chk_word(input logic [ADDR_W-1:0] a);
      n_compared++;
      if ({pout, dout} !== mem[a]) begin
         err_total++;
         $display("mismatch at %0t: word %h at %h, expected %h", $time, {pout, dout}, a, mem[a]);
      end
   endtask : chk_word
   task automatic chk_oe(input logic exp);
      n_compared++;
      if (oe !== exp) begin
         err_total++;
         $display("mismatch at %0t: drive enable %b, expected %b", $time, oe, exp);
      end
   endtask : chk_oe
   task automatic chk_ready(input logic exp);
      n_compared++;
      if (wr_rdy !== exp) begin
         err_total++;
         $display("mismatch at %0t: write ready %b, expected %b", $time, wr_rdy, exp);
      end
   endtask : chk_ready
   task automatic cont(input logic adv_n);
      u_host.cyc(2'h3, SEL_ON, '0, 4'hF, '0, {2'h3, adv_n}, 1'b0);
   endtask : cont
   task automatic rd(input logic [ADDR_W-1:0] a);
      u_host.cyc(2'h1, SEL_ON, a, 4'hF, '0, 3'h7, 1'b0);
   endtask : rd
   task automatic desel();
      u_host.cyc(2'h1, 3'h0, '0, 4'hF, '0, 3'h7, 1'b0);
   endtask : desel
   task automatic oe_set(input logic v);
      u_host.oe_n_out = v;
      repeat (3) cont(1'b1);
   endtask : oe_set
   // expected merge of a write into the model memory
   task automatic put(input logic [ADDR_W-1:0] a, input logic gw_n, input logic gate_n,
                      input logic [LANES-1:0] ln, input logic [WORD_W-1:0] w);
      logic [LANES-1:0] sel_l;
      logic [WORD_W-1:0] r;
      sel_l = !gw_n ? 4'hF : (!gate_n ? ~ln : 4'h0);
      r = mem.exists(a) ? mem[a] : 'x;
      for (int l = 0; l < LANES; l++) begin
         if (sel_l[l]) begin
            r[8*l +: 8] = w[8*l +: 8];
            r[DATA_W + l] = w[DATA_W + l];
         end
      end
      mem[a] = r;
   endtask : put
   task automatic wp(input logic [ADDR_W-1:0] a, input logic gw_n, input logic gate_n,
                     input logic [LANES-1:0] ln, input logic [WORD_W-1:0] w);
      u_host.cyc(2'h1, SEL_ON, a, 4'h0, '0, 3'h0, 1'b0);
      u_host.cyc(2'h3, SEL_ON, a, ln, w, {gw_n, gate_n, 1'b0}, 1'b1);
      put(a, gw_n, gate_n, ln, w);
   endtask : wp
   task automatic wc(input logic [ADDR_W-1:0] a, input logic gw_n, input logic gate_n,
                     input logic [LANES-1:0] ln, input logic [WORD_W-1:0] w);
      u_host.cyc(2'h2, SEL_ON, a, ln, w, {gw_n, gate_n, 1'b0}, 1'b1);
      put(a, gw_n, gate_n, ln, w);
   endtask : wc
   task automatic rd_chk(input logic [ADDR_W-1:0] a);
      rd(a);
      cont(1'b1);
      chk_oe(1'b1);
      chk_word(a);
   endtask : rd_chk
   task automatic do_reset(input logic mode);
      rst_in = 1'b1;
      u_host.burst_order_out = mode;
      repeat (5) @(negedge ref_clk_in);
      rst_in = 1'b0;
      repeat (3) @(negedge ref_clk_in);
   endtask : do_reset

   task automatic s_writes();
      chk_oe(1'b0);
      chk_ready(1'b1);
      wp(17'h00010, 1'b0, 1'b1, 4'hF, 36'hA_1234_5678);
      wp(17'h00011, 1'b0, 1'b0, 4'h0, 36'h5_0F0F_0F0F);
      wp(17'h00011, 1'b1, 1'b0, 4'hA, 36'hF_FFFF_FFFF);
      wc(17'h00012, 1'b0, 1'b1, 4'hF, 36'h3_CAFE_0001);
      wc(17'h00012, 1'b1, 1'b1, 4'h0, 36'hC_0000_0000);
      wc(17'h00012, 1'b1, 1'b0, 4'h7, 36'h8_1111_2222);
      oe_set(1'b0);
      for (int i = 16; i < 19; i++) rd_chk(ADDR_W'(i));
   endtask : s_writes
   task automatic s_burst(input logic mode);
      logic [1:0] k;
      logic [1:0] pv;
      logic [4:0] adv_n;
      do_reset(mode);
      oe_set(1'b1);
      for (int i = 0; i < 4; i++) wc(ADDR_W'(64 + i), 1'b0, 1'b1, 4'hF, 36'h6_0000_0000 | 36'(i * 5));
      oe_set(1'b0);
      adv_n = 5'b00100;
      k = 2'h0;
      pv = 2'h1;
      rd(17'h00041);
      for (int j = 0; j < 5; j++) begin
         cont(adv_n[j]);
         chk_word({15'h0010, pv});
         k = k + {1'b0, !adv_n[j]};
         pv = mode ? (2'h1 ^ k) : (2'h1 + k);
      end
      cont(1'b1);
      chk_word({15'h0010, pv});
   endtask : s_burst
   task automatic s_pipe();
      for (int i = 0; i < 4; i++) begin
         rd(ADDR_W'(64 + i));
         if (i > 0) chk_word(ADDR_W'(63 + i));
      end
      cont(1'b1);
      chk_word(17'h00043);
   endtask : s_pipe
   task automatic s_select();
      rd(17'h00040);
      desel();
      chk_oe(1'b0);
      rd(17'h00042);
      chk_oe(1'b0);
      cont(1'b1);
      chk_oe(1'b1);
      u_host.cyc(2'h1, 3'h6, 17'h00041, 4'hF, '0, 3'h7, 1'b0);
      chk_oe(1'b1);
      chk_word(17'h00042);
      desel();
      u_host.cyc(2'h0, SEL_ON, 17'h00043, 4'hF, '0, 3'h3, 1'b0);
      cont(1'b1);
      chk_word(17'h00043);
      oe_set(1'b1);
      chk_oe(1'b0);
   endtask : s_select
   task automatic s_sleep();
      logic [WORD_W-1:0] old;
      old = mem[17'h00010];
      desel();
      u_host.sleep_request_out = 1'b1;
      repeat (3) cont(1'b1);
      wc(17'h00010, 1'b0, 1'b1, 4'hF, 36'h0_0000_0000);
      mem[17'h00010] = old;
      cont(1'b1);
      chk_oe(1'b0);
      chk_ready(1'b1);
      u_host.sleep_request_out = 1'b0;
      repeat (3) cont(1'b1);
      oe_set(1'b0);
      rd_chk(17'h00010);
   endtask : s_sleep

   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      repeat (3000) @(posedge ref_clk_in);
      err_total++;
      report_and_stop();
   end
   initial begin
      err_total = 0;
      n_compared = 0;
      rst_in = 1'b1;
      @(negedge ref_clk_in);
      do_reset(1'b1);
      s_writes();
      s_burst(1'b0);
      s_burst(1'b1);
      s_pipe();
      s_select();
      s_sleep();
      report_and_stop();
   end
endmodule : pssa_access_test
`default_nettype wire
